// ### design/dfo_framer.sv
// overhead framer: sync, indicators, crc-6, stuffing and scramblers
// assumes bit-serial payload and receive data on the same clock,
// status pins from outside, register access over axi4-lite
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module dfo_framer #(
  parameter int unsigned BIT_DIV = dfo_pkg::BIT_DIV
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // status pins
  input  wire logic        app_los,
  input  wire logic        app_bpv,
  input  wire logic        alarm_pending,
  input  wire logic        primary_supply_status,
  input  wire logic        secondary_supply_status,
  // transmit side
  input  wire logic        tx_pl_bit,
  output logic             tx_pl_take,
  input  wire logic [12:0] tx_eoc,
  output logic             tx_eoc_take,
  input  wire logic        tx_stuff_req,
  output logic             tx_line_bit,
  output logic             tx_line_en,
  output logic             tx_frame_start,
  // receive side
  input  wire logic        rx_bit,
  input  wire logic        rx_bit_en,
  input  wire logic        rx_frame_start,
  input  wire logic        peer_crc_err,
  output logic             rx_pl_bit,
  output logic             rx_pl_valid,
  output logic [12:0]      rx_eoc,
  output logic             rx_eoc_valid,
  output logic             rx_crc_err
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  logic       bpv_d_reg;
  wire  [4:0] pins = {app_los, app_bpv, alarm_pending,
                      primary_supply_status, secondary_supply_status};
  wire  los_s  = pin_s2_reg[4];
  wire  bpv_s  = pin_s2_reg[3];
  wire  alm_s  = pin_s2_reg[2];
  wire  pri_ok = pin_s2_reg[1];
  wire  sec_ok = pin_s2_reg[0];
  wire  bpv_ev = bpv_s & ~bpv_d_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1_reg <= 5'h00;
      pin_s2_reg <= 5'h00;
      bpv_d_reg  <= 1'b0;
    end else begin
      pin_s1_reg <= pins;
      pin_s2_reg <= pin_s1_reg;
      bpv_d_reg  <= bpv_s;
    end
  end

  // ****************************************
  // control register and derived settings
  // ****************************************
  logic [8:0]  ctrl_reg;
  logic [15:0] errcnt_reg;
  logic [12:0] rx_ind_reg;
  wire         en      = ctrl_reg[dfo_pkg::C_EN];
  wire  [1:0]  role    = ctrl_reg[dfo_pkg::C_ROLE +: 2];
  wire         tx_up   = ctrl_reg[dfo_pkg::C_TXUP];
  wire         rx_up   = ctrl_reg[dfo_pkg::C_RXUP];
  wire         face_ln = ctrl_reg[dfo_pkg::C_FACE];
  wire  [1:0]  pairs   = ctrl_reg[dfo_pkg::C_PAIR +: 2];
  wire         is_cust = role == dfo_pkg::ROLE_CUST;
  wire         is_reg  = role == dfo_pkg::ROLE_REGEN;
  // covered length follows the pair count
  wire  [13:0] m_bits  = (pairs == 2'h0) ? dfo_pkg::M_3P :
                         (pairs == 2'h1) ? dfo_pkg::M_2P :
                         dfo_pkg::M_1P;
  wire  [13:0] cov_end = m_bits + dfo_pkg::HOH_NCOV;
  wire  [4:0]  tx_tap  = tx_up ? dfo_pkg::TAP_UP : dfo_pkg::TAP_DN;
  wire  [4:0]  rx_tap  = rx_up ? dfo_pkg::TAP_UP : dfo_pkg::TAP_DN;

  // ****************************************
  // line bit enable divider
  // ****************************************
  localparam logic [7:0] DIV_LAST = 8'(BIT_DIV - 1);
  logic [7:0] div_reg;
  wire        bit_en = en & (div_reg == DIV_LAST);
  always_ff @(posedge clk) begin
    if (!rst_n || !en || bit_en) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // ****************************************
  // transmit position and field decode
  // ****************************************
  dfo_pkg::dfo_tx_e tx_st_reg;
  logic [13:0] tx_pos_reg;
  logic        stuff_reg;
  logic [45:0] ohd_reg;
  logic [5:0]  tx_crc_reg;
  logic [22:0] scr_reg;
  logic        bpv_seen_reg;
  logic        err_ln_reg;
  logic        err_cu_reg;
  wire  [13:0] tx_len  = cov_end + (stuff_reg ? dfo_pkg::N_STUFF
                                               : 14'h0000);
  wire         tx_run  = tx_st_reg == dfo_pkg::TX_RUN;
  wire         tx_step = tx_run & bit_en;
  wire         tx_wrap = tx_step & (tx_pos_reg == tx_len - 14'h0001);
  wire         t_sync  = tx_pos_reg < dfo_pkg::P_EOC;
  wire         t_crc   = (tx_pos_reg >= dfo_pkg::P_CRC) &
                         (tx_pos_reg <= dfo_pkg::P_CRC_L);
  wire         t_pl    = (tx_pos_reg >= dfo_pkg::P_PL) &
                         (tx_pos_reg < cov_end);
  wire         t_stuff = tx_pos_reg >= cov_end;
  wire  [13:0] st_idx  = tx_pos_reg - cov_end;
  wire  [1:0]  st_bit  = 2'h3 - st_idx[1:0];
  // overhead shift register carries sync, eoc, crc and indicators
  wire         t_data  = t_stuff ? dfo_pkg::STUFF_PAT[st_bit] :
                         t_pl    ? tx_pl_bit : ohd_reg[45];
  wire         t_scr   = ~t_sync & ~t_stuff;
  wire         t_cov   = t_scr & ~t_crc;
  wire         scr_bit = t_data ^ scr_reg[tx_tap] ^
                         scr_reg[dfo_pkg::TAP_23];
  wire         t_out   = t_scr ? scr_bit : t_data;
  assign tx_pl_take  = tx_step & t_pl;
  assign tx_eoc_take = tx_wrap | (~tx_run & en);

  // ****************************************
  // crc-6 step, shared by both directions
  // ****************************************
  function automatic logic [5:0] crc_step(input logic [5:0] c,
                                          input logic       d);
    logic fb;
    fb = d ^ c[5];
    crc_step = {c[4:0], 1'b0} ^ (fb ? dfo_pkg::CRC_POLY : 6'h00);
  endfunction
  wire  [5:0]  tx_crc_nx = t_cov ? crc_step(tx_crc_reg, t_data)
                                 : tx_crc_reg;

  // ****************************************
  // indicator bits for the next frame
  // ****************************************
  wire         ends    = ~is_reg;
  wire         i_losd  = ~(ends & los_s);
  wire         i_febe  = ~(ends & (err_ln_reg | err_cu_reg));
  wire         i_ps1   = ~is_cust | pri_ok;
  wire         i_ps2   = ~is_cust | sec_ok;
  wire         i_bpv   = ~(ends & (bpv_seen_reg | bpv_ev));
  wire         i_hrp   = ~is_reg;
  wire         i_rrbe  = ~(is_reg & err_ln_reg);
  wire         i_rcbe  = ~(is_reg & err_cu_reg);
  wire         i_rta   = ~(is_cust & alm_s);
  wire         i_rega  = ~(is_reg & alm_s);
  wire         i_rdy   = ~ctrl_reg[dfo_pkg::C_RDY];
  // two spare positions and unused ones stay at one
  wire  [12:0] ind_nx  = {i_losd, i_febe, i_ps1, i_ps2, i_bpv,
                          i_hrp, i_rrbe, i_rcbe, i_rta, i_rega,
                          i_rdy, 2'b11};
  // crc of the frame just ended goes into the next one
  wire  [45:0] ohd_ld  = {dfo_pkg::SYNC_PAT, tx_eoc,
                          tx_run ? tx_crc_nx : 6'h00,
                          ind_nx};

  // ****************************************
  // transmit state
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n || !en) begin
      tx_st_reg <= dfo_pkg::TX_IDLE;
    end else begin
      case (tx_st_reg)
        dfo_pkg::TX_IDLE: tx_st_reg <= dfo_pkg::TX_RUN;
        dfo_pkg::TX_RUN:  tx_st_reg <= dfo_pkg::TX_RUN;
        default:          tx_st_reg <= dfo_pkg::TX_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_pos_reg <= 14'h0000;
      stuff_reg  <= 1'b0;
      ohd_reg    <= 46'h0;
      tx_crc_reg <= 6'h00;
    end else if (tx_eoc_take) begin
      tx_pos_reg <= 14'h0000;
      stuff_reg  <= tx_stuff_req;
      ohd_reg    <= ohd_ld;
      tx_crc_reg <= 6'h00;
    end else if (tx_step) begin
      tx_pos_reg <= tx_pos_reg + 14'h0001;
      ohd_reg    <= t_pl ? ohd_reg : {ohd_reg[44:0], 1'b1};
      tx_crc_reg <= tx_crc_nx;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scr_reg <= 23'h0;
    end else if (tx_step && t_scr) begin
      scr_reg <= {scr_reg[21:0], scr_bit};
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_line_bit    <= 1'b1;
      tx_line_en     <= 1'b0;
      tx_frame_start <= 1'b0;
    end else begin
      tx_line_bit    <= tx_step ? t_out : tx_line_bit;
      tx_line_en     <= tx_step;
      tx_frame_start <= tx_step & (tx_pos_reg == 14'h0000);
    end
  end

  // ****************************************
  // events held until the next frame start
  // ****************************************
  wire rx_err_ev;
  // only a regenerator has a second receiver to report for
  wire peer_ev = is_reg & peer_crc_err;
  wire ln_ev = face_ln ? rx_err_ev : peer_ev;
  wire cu_ev = face_ln ? peer_ev : rx_err_ev;
  // an event in the capture cycle is kept for the frame after
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bpv_seen_reg <= 1'b0;
      err_ln_reg   <= 1'b0;
      err_cu_reg   <= 1'b0;
    end else begin
      bpv_seen_reg <= bpv_ev | (bpv_seen_reg & ~tx_eoc_take);
      err_ln_reg   <= ln_ev | (err_ln_reg & ~tx_eoc_take);
      err_cu_reg   <= cu_ev | (err_cu_reg & ~tx_eoc_take);
    end
  end

  // ****************************************
  // receive path
  // ****************************************
  logic [13:0] rx_pos_reg;
  logic [22:0] dsc_reg;
  logic [5:0]  rx_crc_reg;
  logic [5:0]  crc_prev_reg;
  logic [5:0]  crc_rcv_reg;
  logic [12:0] eoc_sh_reg;
  logic [12:0] ind_sh_reg;
  logic        seen_reg;
  logic        have_prev_reg;
  wire  [13:0] r_pos   = rx_frame_start ? 14'h0000 : rx_pos_reg;
  wire         r_step  = en & rx_bit_en;
  wire         r_scr   = (r_pos >= dfo_pkg::P_EOC) &
                         (r_pos < cov_end);
  wire         r_crc   = (r_pos >= dfo_pkg::P_CRC) &
                         (r_pos <= dfo_pkg::P_CRC_L);
  wire         r_pl    = (r_pos >= dfo_pkg::P_PL) & r_scr;
  wire         r_data  = rx_bit ^ dsc_reg[rx_tap] ^
                         dsc_reg[dfo_pkg::TAP_23];
  wire  [5:0]  crc_got = {crc_rcv_reg[4:0], r_data};
  wire         r_chk   = r_step & (r_pos == dfo_pkg::P_CRC_L);
  assign rx_err_ev = r_chk & have_prev_reg &
                     (crc_got != crc_prev_reg);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_pos_reg <= 14'h0000;
      dsc_reg    <= 23'h0;
    end else if (r_step) begin
      rx_pos_reg <= (r_pos == 14'h3fff) ? r_pos : r_pos + 14'h0001;
      dsc_reg    <= r_scr ? {dsc_reg[21:0], rx_bit}
                          : dsc_reg;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_crc_reg    <= 6'h00;
      crc_prev_reg  <= 6'h00;
      seen_reg      <= 1'b0;
      have_prev_reg <= 1'b0;
    end else if (r_step && r_pos == 14'h0000) begin
      crc_prev_reg  <= rx_crc_reg;
      rx_crc_reg    <= 6'h00;
      seen_reg      <= 1'b1;
      have_prev_reg <= seen_reg;
    end else if (r_step && r_scr && !r_crc) begin
      rx_crc_reg    <= crc_step(rx_crc_reg, r_data);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crc_rcv_reg <= 6'h00;
      eoc_sh_reg  <= 13'h0;
      ind_sh_reg  <= 13'h0;
    end else if (r_step) begin
      crc_rcv_reg <= r_crc ? crc_got : crc_rcv_reg;
      eoc_sh_reg  <= {eoc_sh_reg[11:0], r_data};
      ind_sh_reg  <= {ind_sh_reg[11:0], r_data};
    end
  end
  wire r_eoc_l = r_step & (r_pos == dfo_pkg::P_EOC_L);
  wire r_ind_l = r_step & (r_pos == dfo_pkg::P_IND_L);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_eoc       <= 13'h1fff;
      rx_eoc_valid <= 1'b0;
      rx_ind_reg   <= 13'h1fff;
      rx_pl_bit    <= 1'b0;
      rx_pl_valid  <= 1'b0;
      rx_crc_err   <= 1'b0;
    end else begin
      rx_eoc       <= r_eoc_l ? {eoc_sh_reg[11:0], r_data}
                              : rx_eoc;
      rx_eoc_valid <= r_eoc_l;
      rx_ind_reg   <= r_ind_l ? {ind_sh_reg[11:0], r_data}
                              : rx_ind_reg;
      rx_pl_bit    <= (r_step && r_pl) ? r_data : rx_pl_bit;
      rx_pl_valid  <= r_step & r_pl;
      rx_crc_err   <= rx_err_ev;
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic       aw_hold_reg;
  logic       w_hold_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  wire  do_wr    = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  wire  wr_ctrl  = do_wr & (awaddr_reg == dfo_pkg::A_CTRL);
  wire  wr_cnt   = do_wr & (awaddr_reg == dfo_pkg::A_ERRCNT);
  wire  wr_ok    = wr_ctrl | wr_cnt;
  wire  [8:0] ctrl_nx = {wstrb_reg[1] ? wdata_reg[8] : ctrl_reg[8],
                         wstrb_reg[0] ? wdata_reg[7:0]
                                      : ctrl_reg[7:0]};
  assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_hold_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_hold_reg <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (do_wr) begin
      w_hold_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dfo_pkg::RESP_OK;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? dfo_pkg::RESP_OK : dfo_pkg::RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // counter clear with a crc error in the same cycle leaves the count at one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg   <= dfo_pkg::CTRL_RST;
      errcnt_reg <= 16'h0000;
    end else begin
      ctrl_reg   <= wr_ctrl ? ctrl_nx : ctrl_reg;
      errcnt_reg <= rx_err_ev ? (wr_cnt ? 16'h0001
                                        : errcnt_reg + 16'h0001)
                              : (wr_cnt ? 16'h0000 : errcnt_reg);
    end
  end
  wire r_ctl = s_axi_araddr == dfo_pkg::A_CTRL;
  wire r_sta = s_axi_araddr == dfo_pkg::A_STATUS;
  wire r_cnt = s_axi_araddr == dfo_pkg::A_ERRCNT;
  wire r_eoc = s_axi_araddr == dfo_pkg::A_RXEOC;
  wire [31:0] rd_mux =
    r_ctl ? {23'h0, ctrl_reg} :
    r_sta ? {16'h0000, have_prev_reg, seen_reg, tx_run, rx_ind_reg} :
    r_cnt ? {16'h0000, errcnt_reg} :
    r_eoc ? {19'h0, rx_eoc} : 32'h0000_0000;
  wire rd_ok = r_ctl | r_sta | r_cnt | r_eoc;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= dfo_pkg::RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? dfo_pkg::RESP_OK : dfo_pkg::RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### design/dfo_pkg.sv
// constants for the 2b1q frame overhead, crc and scrambler block
// assumes one 20 mhz clock and a line bit enable derived from it
package dfo_pkg;
  // clock and line rate
  localparam int unsigned CLK_HZ  = 20_000_000;
  localparam int unsigned BIT_HZ  = 784_000;
  localparam int unsigned BIT_DIV = CLK_HZ / BIT_HZ;
  // frame layout, bit positions from the frame start
  localparam logic [13:0] SYNC_PAT = 14'h2a08;
  localparam logic [13:0] P_EOC    = 14'h000e;
  localparam logic [13:0] P_CRC    = 14'h001b;
  localparam logic [13:0] P_CRC_L  = 14'h0020;
  localparam logic [13:0] P_IND    = 14'h0021;
  localparam logic [13:0] P_EOC_L  = 14'h001a;
  localparam logic [13:0] P_IND_L  = 14'h002d;
  localparam logic [13:0] P_PL     = 14'h002e;
  localparam logic [13:0] HOH_NCOV = 14'h0014;
  localparam logic [13:0] N_STUFF  = 14'h0004;
  localparam logic [3:0]  STUFF_PAT = 4'ha;
  // covered bits per frame for three, two and one pair
  localparam logic [13:0] M_3P = 14'd4682;
  localparam logic [13:0] M_2P = 14'd6986;
  localparam logic [13:0] M_1P = 14'd13888;
  // crc x^6+x+1 and scrambler taps
  localparam logic [5:0] CRC_POLY = 6'h03;
  localparam logic [4:0] TAP_23   = 5'h16;
  localparam logic [4:0] TAP_UP   = 5'h11;
  localparam logic [4:0] TAP_DN   = 5'h04;
  // unit roles
  localparam logic [1:0] ROLE_LINE  = 2'h0;
  localparam logic [1:0] ROLE_CUST  = 2'h1;
  localparam logic [1:0] ROLE_REGEN = 2'h2;
  // register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_ERRCNT = 8'h08;
  localparam logic [7:0] A_RXEOC  = 8'h0c;
  // control fields
  localparam int C_EN   = 0;
  localparam int C_ROLE = 1;
  localparam int C_TXUP = 3;
  localparam int C_FACE = 4;
  localparam int C_PAIR = 5;
  localparam int C_RDY  = 7;
  localparam int C_RXUP = 8;
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic {TX_IDLE, TX_RUN} dfo_tx_e;
endpackage

// ### sim/dfo_monitor.sv
// checker for the overhead framer, bound to its ports
// assumes one clock and a three, two or one pair frame
`timescale 1ns/10ps
`default_nettype none
module dfo_monitor (
  // watched ports
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] s_axi_araddr,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       tx_pl_take,
  input wire logic       tx_line_bit,
  input wire logic       tx_line_en,
  input wire logic       tx_frame_start,
  input wire logic       rx_bit_en,
  input wire logic       rx_frame_start,
  input wire logic       rx_eoc_valid,
  input wire logic       rx_crc_err
);
  // ****
  // bit counters
  // ****
  logic [13:0] tx_cnt_reg;
  logic [13:0] rx_cnt_reg;
  wire  [13:0] tx_idx = tx_frame_start ? 14'h0000 : tx_cnt_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) tx_cnt_reg <= 14'h0000;
    else if (tx_frame_start) tx_cnt_reg <= 14'h0001;
    else if (tx_line_en) tx_cnt_reg <= tx_cnt_reg + 14'h0001;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) rx_cnt_reg <= 14'h0000;
    else if (rx_frame_start) rx_cnt_reg <= 14'h0001;
    else if (rx_bit_en) rx_cnt_reg <= rx_cnt_reg + 14'h0001;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sync_word_a: assert property (tx_line_en && tx_idx < 14'h000e |->
    tx_line_bit == dfo_pkg::SYNC_PAT[4'hd - tx_idx[3:0]])
    else $error("sync bit wrong");
  frame_len_a: assert property (tx_frame_start |-> tx_cnt_reg inside
    {14'h0000, 14'h125e, 14'h1262, 14'h1b5e, 14'h1b62, 14'h3654, 14'h3658})
    else $error("frame length wrong");
  pl_slot_a: assert property (tx_pl_take |-> tx_cnt_reg >= dfo_pkg::P_PL)
    else $error("payload in overhead");
  eoc_slot_a: assert property (rx_eoc_valid |-> rx_cnt_reg == 14'h001b)
    else $error("eoc out of place");
  crc_slot_a: assert property (rx_crc_err |-> rx_cnt_reg == 14'h0021)
    else $error("crc flag out of place");
  reset_idle_a: assert property ($rose(rst_n) |-> tx_line_bit && !tx_line_en)
    else $error("line not idle");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rresp))
    else $error("read answer dropped");
  bad_addr_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[7:4] != 4'h0 |=> s_axi_rresp == dfo_pkg::RESP_ERR)
    else $error("unmapped read ok");
  cover property (rx_crc_err);
  cover property (tx_frame_start && tx_cnt_reg == 14'h1262);
  cover property (s_axi_rvalid && s_axi_rresp == dfo_pkg::RESP_ERR);
endmodule
bind dfo_framer dfo_monitor u_mon (.*);
`default_nettype wire

// ### sim/dfo_line_partner.sv
// far transceiver: returns our line frames after a delay
// assumes line strobes on the same clock as the framer
`timescale 1ns/10ps
`default_nettype none
module dfo_line_partner (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // line from the framer
  input  wire logic       tx_line_bit,
  input  wire logic       tx_line_en,
  input  wire logic       tx_frame_start,
  // delay in clocks minus one and one-shot bit error
  input  wire logic [2:0] dly,
  input  wire logic       flip,
  // line toward the framer
  output logic            rx_bit,
  output logic            rx_bit_en,
  output logic            rx_frame_start
);
  // ****
  // loopback line
  // ****
  logic [7:0] bit_reg;
  logic [7:0] en_reg;
  logic [7:0] fs_reg;
  logic       arm_reg;
  logic       last_reg;
  // an armed error hits exactly one line bit
  wire        hit = arm_reg & tx_line_en;
  always_ff @(posedge clk) begin
    bit_reg  <= {bit_reg[6:0], tx_line_bit ^ hit};
    en_reg   <= rst_n ? {en_reg[6:0], tx_line_en} : 8'h00;
    fs_reg   <= {fs_reg[6:0], tx_frame_start};
    arm_reg  <= rst_n & (flip | (arm_reg & ~tx_line_en));
    last_reg <= rst_n ? rx_bit : 1'b0;
  end
  assign rx_bit_en      = en_reg[dly];
  assign rx_frame_start = fs_reg[dly] & rx_bit_en;
  // idle line toggles so no stale level passes for data
  assign rx_bit         = rx_bit_en ? bit_reg[dly] : ~last_reg;
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// loopback bench for the overhead framer and its registers
// assumes the partner returns every line bit unchanged except one flipped bit in the customer run
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ****
  // signals
  // ****
  logic clk = 1'b0, rst_n = 1'b0, flip = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, tx_pl_take, tx_eoc_take, tx_line_bit, tx_line_en;
  logic app_los = 1'b0, app_bpv = 1'b0, alarm_pending = 1'b0;
  logic primary_supply_status = 1'b1, secondary_supply_status = 1'b1;
  logic tx_pl_bit = 1'b0, tx_stuff_req = 1'b0, peer_crc_err = 1'b0;
  logic [12:0] tx_eoc = 13'h0000, rx_eoc, eocq[$];
  logic tx_frame_start, rx_bit, rx_bit_en, rx_frame_start, rx_pl_bit;
  logic rx_pl_valid, rx_eoc_valid, rx_crc_err, cur_st, pend_st, plq[$];
  logic [2:0] dly = 3'h1;
  int seed = 88585, miscompares = 0, total_checks = 0;
  int fs_cnt, bit_cnt, pl_bad, pl_n, eoc_n, crc_n, flen;
  dfo_framer #(.BIT_DIV(2)) dut (.*);
  dfo_line_partner far_end (.*);
  initial forever #25 clk = ~clk;
  always @(posedge clk) {tx_pl_bit, tx_stuff_req, tx_eoc} <= 15'($random(seed));
  // ****
  // reference model of the looped stream
  // ****
  always @(posedge clk) if (rst_n) begin
    if (tx_pl_take) plq.push_back(tx_pl_bit);
    if (tx_eoc_take) begin
      eocq.push_back(tx_eoc);
      pend_st = tx_stuff_req;
    end
    if (tx_frame_start) begin
      if (bit_cnt != 0) chk(bit_cnt == flen + 4 * cur_st, "length");
      cur_st = pend_st;
      bit_cnt = 0;
      fs_cnt++;
    end
    if (tx_line_en) bit_cnt++;
    if (rx_eoc_valid) begin
      eoc_n++;
      chk(eocq.size() > 0 && rx_eoc === eocq.pop_front(), "eoc");
    end
    if (rx_pl_valid) begin
      pl_n++;
      if (plq.size() == 0 || rx_pl_bit !== plq.pop_front()) pl_bad++;
    end
    if (rx_crc_err) crc_n++;
  end
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(negedge clk); while (!s_axi_awready);
        @(posedge clk);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(negedge clk); while (!s_axi_wready);
        @(posedge clk);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(negedge clk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge clk); while (!s_axi_arready);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    // late ready keeps the read answer waiting for a cycle
    @(posedge clk);
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_fs(input int n, input int k);
    while (fs_cnt < n) @(posedge clk);
    repeat (k) @(posedge clk);
  endtask
  // ****
  // one role per run: line, regenerator, customer with a line error
  // ****
  task automatic run_cfg(input int c);
    logic up, rdy, bpv_ev, pe_ev;
    logic [12:0] ind;
    logic [8:0] ctl;
    logic [1:0] sel;
    up = c != 0;
    {rdy, bpv_ev, pe_ev} = 3'($random(seed));
    rst_n <= 1'b0;
    {app_los, alarm_pending, primary_supply_status,
     secondary_supply_status} <= 4'($random(seed));
    dly <= c == 1 ? 3'h7 : 3'h1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    {fs_cnt, bit_cnt, pl_bad, pl_n, eoc_n, crc_n} = 0;
    // covered bits plus sync and crc, no stuffing
    flen = c == 0 ? 4702 : c == 1 ? 13908 : 7006;
    eocq.delete();
    plq.delete();
    rd(dfo_pkg::A_CTRL);
    chk(rv[8:0] === dfo_pkg::CTRL_RST, "ctrl reset");
    rd(8'h10);
    chk(rs === dfo_pkg::RESP_ERR && rv === 32'h0000_0000, "bad read");
    // role and pairs: line on 3 pairs, regenerator 1, customer 2
    sel = 2'(c == 1 ? 2 : c == 2);
    ctl = {up, rdy, sel, c == 1, up, sel, 1'b1};
    wr(dfo_pkg::A_CTRL, {23'h00_0000, ctl});
    rd(dfo_pkg::A_CTRL);
    chk(rs === dfo_pkg::RESP_OK && rv[8:0] === ctl, "ctrl");
    wait_fs(1, 200);
    app_bpv <= bpv_ev;
    peer_crc_err <= pe_ev;
    flip <= c == 2;
    @(posedge clk);
    peer_crc_err <= 1'b0;
    flip <= 1'b0;
    repeat (4) @(posedge clk);
    app_bpv <= 1'b0;
    ind = c == 0 ? {~app_los, 3'h7, ~bpv_ev, 5'h1f, ~rdy, 2'h3}
        : c == 1 ? {6'h3e, 1'b1, ~pe_ev, 1'b1, ~alarm_pending, ~rdy, 2'h3}
        : {~app_los, 1'b1, primary_supply_status, secondary_supply_status,
           ~bpv_ev, 3'h7, ~alarm_pending, 1'b1, ~rdy, 2'h3};
    wait_fs(2, 150);
    rd(dfo_pkg::A_STATUS);
    chk(rv[15:0] === {3'h7, ind}, "ind");
    if (c == 2) begin
      wait_fs(3, 150);
      rd(dfo_pkg::A_STATUS);
      chk(rv[12:0] === ((ind | 13'h0100) & 13'h17ff), "febe");
      rd(dfo_pkg::A_ERRCNT);
      chk(rv[15:0] === 16'h0001, "errcnt");
      wr(dfo_pkg::A_ERRCNT, 32'h0000_0000);
      rd(dfo_pkg::A_ERRCNT);
      chk(rv[15:0] === 16'h0000, "clear");
    end
    chk(crc_n == (c == 2) && eoc_n >= 2 && pl_n > 1000, "loop");
    chk(pl_bad == (c == 2 ? 3 : 0), "payload");
    wr(8'h14, 32'h0000_0000);
    chk(rs === dfo_pkg::RESP_ERR, "bad write");
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    $display("Error %0t: timeout", $time);
    conclude;
  end
  initial begin
    for (int c = 0; c < 3; c++) run_cfg(c);
    conclude;
  end
endmodule
`default_nettype wire
